/* File: dv/acq_ctrl_properties.sv */
module acq_ctrl_checker (
  // clock and reset
  input wire logic                           core_clk,
  input wire logic                           nrst,
  // configuration, commands and external pins
  input wire logic                           cfg_load,
  input wire acq_pkg::clk_src_e              cfg_clk_src,
  input wire acq_pkg::trig_src_e             cfg_trig_src,
  input wire logic [acq_pkg::COUNT_W-1:0]    cfg_sample_total,
  input wire logic [acq_pkg::PRETRIG_W-1:0]  cfg_pretrig_count,
  input wire logic                           cfg_route_clk_out,
  input wire logic                           cfg_route_trig_out,
  input wire logic                           stop_cmd,
  input wire logic                           clear_trig_cmd,
  input wire logic                           analog_in_host_trigger_cmd,
  input wire logic                           ext_sample_clk_in,
  input wire logic                           ext_trig_in,
  // observed outputs
  input wire logic                           conv_start,
  input wire logic                           sample_clk_out,
  input wire logic                           trig_out,
  input wire logic                           triggered,
  input wire logic                           acq_busy,
  input wire logic                           acq_done,
  input wire logic [acq_pkg::COUNT_W-1:0]    samples_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  // shadow of the captured settings, so checks follow what the block really uses
  logic [29:0] cfg_reg;
  wire  [21:0] total_c  = (cfg_sample_total == 22'h000000) ? 22'h000001 :
                          (cfg_sample_total > 22'h200000) ? 22'h200000 : cfg_sample_total;
  wire         ext_clk  = cfg_reg[29];
  wire  [3:0]  trig_sel = cfg_reg[28:25];
  wire         rclk     = cfg_reg[24];
  wire         rtrig    = cfg_reg[23];
  wire         pre0     = cfg_reg[22];
  wire  [21:0] total    = cfg_reg[21:0];
  wire         armed    = acq_busy && !triggered;
  wire         quiet    = !clear_trig_cmd && !stop_cmd;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_reg <= 30'h00400400;
    end else if (cfg_load && !acq_busy) begin
      cfg_reg <= {cfg_clk_src, cfg_trig_src, cfg_route_clk_out, cfg_route_trig_out,
                  cfg_pretrig_count == 13'h0000, total_c};
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_idle_quiet;
    !acq_busy |=> !conv_start;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("conversion while idle");
  property p_ext_clk;
    ext_clk && triggered && quiet && $rose(ext_sample_clk_in) |=> conv_start;
  endproperty
  a_ext_clk: assert property (p_ext_clk) else $error("external edge not converted");
  property p_ext_trig;
    trig_sel == acq_pkg::TRIG_EXT_IN && armed && quiet && $rose(ext_trig_in) |=> triggered;
  endproperty
  a_ext_trig: assert property (p_ext_trig) else $error("external trigger missed");
  property p_ai_trig;
    trig_sel == acq_pkg::TRIG_AI_CMD && armed && quiet && analog_in_host_trigger_cmd
      |=> triggered;
  endproperty
  a_ai_trig: assert property (p_ai_trig) else $error("host trigger missed");
  property p_clear;
    triggered && clear_trig_cmd && !stop_cmd |=> !triggered && acq_busy;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not untrigger");
  property p_trig_out;
    trig_out == (triggered && rtrig);
  endproperty
  a_trig_out: assert property (p_trig_out) else $error("trigger pin wrong");
  property p_clk_out;
    sample_clk_out && $stable(cfg_reg) |-> rclk ##1 !sample_clk_out;
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock pin wrong");
  property p_done;
    acq_done |-> !acq_busy && !triggered && samples_taken == total ##1 !acq_done;
  endproperty
  a_done: assert property (p_done) else $error("finite run ended wrongly");
  property p_pre0;
    armed && pre0 |=> !conv_start;
  endproperty
  a_pre0: assert property (p_pre0) else $error("sampling before trigger");
endmodule

bind ai_acq_ctrl acq_ctrl_checker i_acq_ctrl_checker (.*);

/* File: dv/host_adc_model.sv */
module host_adc_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // converter side
  input  wire logic        conv_start,
  output logic             adc_valid,
  output logic [15:0]      adc_data,
  // host side
  input  wire logic        up_valid,
  input  wire logic [15:0] up_data,
  output logic             up_ready,
  input  wire logic        slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt;
  logic [15:0] got[$];

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 16'h0000;
      adc_valid <= 1'b0;
      adc_data <= 16'hFFFF;
      up_ready <= 1'b0;
    end else begin
      adc_valid <= conv_start;
      // data bus shows junk outside a valid beat
      adc_data <= conv_start ? cnt + 16'h0001 : ~adc_data;
      if (conv_start) cnt <= cnt + 16'h0001;
      if (up_valid && up_ready) got.push_back(up_data);
      // a slow host stalls every other cycle so words wait in the buffer
      up_ready <= slow ? !up_ready : 1'b1;
    end
  end
endmodule

/* File: dv/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                core_clk = 1'b0;
  logic                nrst, cfg_load, cfg_finite_count_mode, cfg_route_clk_out;
  logic                cfg_route_trig_out, arm_cmd, stop_cmd, clear_trig_cmd, slow;
  logic                analog_in_host_trigger_cmd, global_host_trigger_cmd;
  logic                ext_sample_clk_in, ext_trig_in, di_trig_evt, do_trig_evt;
  logic                conv_start, adc_valid, up_valid, up_ready, sample_clk_out;
  logic                trig_out, triggered, acq_busy, acq_done, overflow;
  acq_pkg::clk_src_e   cfg_clk_src;
  acq_pkg::trig_src_e  cfg_trig_src;
  logic [0:0]          cfg_dio_sel;
  logic [21:0]         cfg_sample_total, samples_taken;
  logic [12:0]         cfg_pretrig_count;
  logic [23:0]         cfg_period_steps;
  logic [1:0]          digital_io_pin, digital_io_is_input;
  logic [3:0]          ao_trig_evt;
  logic [15:0]         adc_data, up_data;
  int                  num_errors = 0;
  int                  n_compared = 0;
  int                  n, t0, nconv, nclk, base;
  localparam int FAST = acq_pkg::MIN_PERIOD_STEPS * acq_pkg::TIMER_STEP_NS
                      / acq_pkg::CLK_PERIOD_NS;

  always #2 core_clk = ~core_clk;
  ai_acq_ctrl i_ai_acq_ctrl (.*);
  host_adc_model i_host_adc_model (.*);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_conv(output int k);
    k = 0;
    while (conv_start !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
    if (k == 2000) begin
      num_errors++;
      wrap_up();
    end
    tick(1);
  endtask
  task automatic setup(input acq_pkg::clk_src_e c, input acq_pkg::trig_src_e t,
                       input logic fin, input logic [21:0] tot, input logic [12:0] pre,
                       input logic [23:0] per);
    cfg_clk_src = c;
    cfg_trig_src = t;
    cfg_finite_count_mode = fin;
    cfg_sample_total = tot;
    cfg_pretrig_count = pre;
    cfg_period_steps = per;
    pulse(cfg_load);
  endtask
  task automatic fire(input int k);
    case (k)
      0: analog_in_host_trigger_cmd = 1'b1;
      1: global_host_trigger_cmd = 1'b1;
      2: ext_trig_in = 1'b1;
      3: digital_io_pin[1] = 1'b1;
      4: di_trig_evt = 1'b1;
      5: do_trig_evt = 1'b1;
      default: ao_trig_evt[k-6] = 1'b1;
    endcase
    tick(1);
    {analog_in_host_trigger_cmd, global_host_trigger_cmd, ext_trig_in} = 3'h0;
    {di_trig_evt, do_trig_evt, digital_io_pin, ao_trig_evt} = 8'h00;
  endtask
  task automatic ext_edge;
    ext_sample_clk_in = 1'b1;
    tick(2);
    ext_sample_clk_in = 1'b0;
    tick(2);
  endtask

  initial begin
    {nrst, cfg_load, cfg_finite_count_mode, cfg_route_clk_out, arm_cmd, stop_cmd} = 6'h00;
    {clear_trig_cmd, analog_in_host_trigger_cmd, global_host_trigger_cmd, slow} = 4'h0;
    {ext_sample_clk_in, ext_trig_in, di_trig_evt, do_trig_evt} = 4'h0;
    {digital_io_pin, ao_trig_evt, cfg_dio_sel} = 7'h01;
    digital_io_is_input = 2'b11;
    cfg_route_trig_out = 1'b1;
    cfg_clk_src = acq_pkg::CLK_SRC_INTERNAL;
    cfg_trig_src = acq_pkg::TRIG_AI_CMD;
    {cfg_sample_total, cfg_pretrig_count, cfg_period_steps} = 59'h0;
    repeat (10) @(posedge core_clk);
    #1 nrst = 1'b1;
    tick(1);
    chk({acq_busy, triggered, conv_start, overflow, trig_out, up_valid}, 6'h00);
    pulse(arm_cmd);
    chk(acq_busy, 1'b1);
    fire(4);
    chk(triggered, 1'b0);
    fire(0);
    chk({triggered, trig_out}, 2'b10);
    wait_conv(n);
    wait_conv(n);
    chk(n + 1, 250);
    pulse(stop_cmd);
    chk(acq_busy, 1'b0);
    $display("defaults test done");
    // total kept far below the two-million ceiling a host must respect
    cfg_route_clk_out = 1'b1;
    slow = 1'b1;
    setup(acq_pkg::CLK_SRC_INTERNAL, acq_pkg::TRIG_EXT_IN, 1'b1, 22'h000004, 13'h0000,
          24'h000005);
    tick(20);
    i_host_adc_model.got.delete();
    pulse(arm_cmd);
    tick(60);
    fire(2);
    chk({triggered, trig_out}, 2'b11);
    {nconv, nclk, t0, n} = 128'h0;
    for (int i = 0; i < 400; i++) begin
      if (sample_clk_out === 1'b1) nclk++;
      if (conv_start === 1'b1) begin
        if (nconv == 0) t0 = i;
        nconv++;
        n = i - t0;
      end
      if (acq_done === 1'b1) break;
      tick(1);
    end
    chk(acq_done, 1'b1);
    chk(nconv, 4);
    chk(n, 3 * FAST);
    chk(nclk >= 3, 1'b1);
    tick(20);
    chk({samples_taken, acq_busy}, {22'h000004, 1'b0});
    chk(i_host_adc_model.got.size(), 4);
    $display("finite test done");
    setup(acq_pkg::CLK_SRC_EXTERNAL, acq_pkg::TRIG_DIO_EDGE, 1'b1, 22'h000002, 13'h0003,
          24'h000064);
    pulse(arm_cmd);
    i_host_adc_model.got.delete();
    base = i_host_adc_model.cnt;
    repeat (5) ext_edge();
    chk(i_host_adc_model.got.size(), 0);
    digital_io_is_input = 2'b01;
    fire(3);
    chk(triggered, 1'b0);
    digital_io_is_input = 2'b11;
    tick(1);
    fire(3);
    chk(triggered, 1'b1);
    repeat (2) ext_edge();
    tick(20);
    chk(i_host_adc_model.got.size(), 5);
    for (int i = 0; i < 5; i++) chk(i_host_adc_model.got[i], base + 3 + i);
    chk({acq_busy, triggered}, 2'b00);
    $display("pre-trigger test done");
    slow = 1'b0;
    for (int s = 0; s < 10; s++) begin
      setup(acq_pkg::CLK_SRC_INTERNAL, acq_pkg::trig_src_e'(s), 1'b0, 22'h000004, 13'h0000,
            24'h000064);
      pulse(arm_cmd);
      fire((s + 3) % 8 + 2);
      chk(triggered, 1'b0);
      fire(s);
      chk({triggered, trig_out}, 2'b11);
      pulse(clear_trig_cmd);
      chk({triggered, acq_busy}, 2'b01);
      pulse(stop_cmd);
      chk(acq_busy, 1'b0);
    end
    $display("trigger source test done");
    wrap_up();
  end
endmodule

/* File: pkg/acq_pkg.sv */
package acq_pkg;

  // clock and timer granularity
  localparam int CLK_PERIOD_NS  = 4;
  localparam int TIMER_STEP_NS  = 10;

  // widths
  localparam int DATA_W         = 16;
  localparam int PERIOD_W       = 24;
  localparam int COUNT_W        = 22;
  localparam int PRETRIG_W      = 13;
  localparam int DIO_W          = 2;
  localparam int DIO_IDX_W      = 1;

  // limits
  localparam int MAX_FINITE_COUNT = 2097152;
  localparam int MAX_PRETRIG      = 4096;
  localparam int MIN_PERIOD_STEPS = 10;

  // reset values of the configuration
  localparam logic [PERIOD_W-1:0]  RST_PERIOD  = 24'h000064;
  localparam logic [COUNT_W-1:0]   RST_COUNT   = 22'h000400;
  localparam logic [PRETRIG_W-1:0] RST_PRETRIG = 13'h0000;

  typedef enum logic {
    CLK_SRC_INTERNAL,
    CLK_SRC_EXTERNAL
  } clk_src_e;

  typedef enum logic [3:0] {
    TRIG_AI_CMD,
    TRIG_GLOBAL_CMD,
    TRIG_EXT_IN,
    TRIG_DIO_EDGE,
    TRIG_DI_FUNC,
    TRIG_DO_FUNC,
    TRIG_AO0_FUNC,
    TRIG_AO1_FUNC,
    TRIG_AO2_FUNC,
    TRIG_AO3_FUNC
  } trig_src_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_RUN
  } acq_state_e;

endpackage

/* File: pkg/sample_fifo_if.sv */
interface sample_fifo_if #(
  parameter int W     = 16,
  parameter int LVL_W = 13
);
  logic             flush;
  logic             push;
  logic [W-1:0]     wdata;
  logic             pop;
  logic [W-1:0]     rdata;
  logic [LVL_W-1:0] level;
  logic             full;
  logic             empty;

  modport ctrl (output flush, output push, output wdata, output pop,
                input rdata, input level, input full, input empty);
  modport store (input flush, input push, input wdata, input pop,
                 output rdata, output level, output full, output empty);
endinterface

/* File: src/ai_acq_ctrl.sv */
module ai_acq_ctrl #(
  parameter int DATA_W           = acq_pkg::DATA_W,
  parameter int FIFO_DEPTH       = acq_pkg::MAX_PRETRIG,
  parameter int MIN_PERIOD_STEPS = acq_pkg::MIN_PERIOD_STEPS
) (
  // clock and reset
  input  wire logic                             core_clk,
  input  wire logic                             nrst,
  // configuration, captured on cfg_load while idle
  input  wire logic                             cfg_load,
  input  wire acq_pkg::clk_src_e                cfg_clk_src,
  input  wire acq_pkg::trig_src_e               cfg_trig_src,
  input  wire logic [acq_pkg::DIO_IDX_W-1:0]    cfg_dio_sel,
  input  wire logic                             cfg_finite_count_mode,
  input  wire logic [acq_pkg::COUNT_W-1:0]      cfg_sample_total,
  input  wire logic [acq_pkg::PRETRIG_W-1:0]    cfg_pretrig_count,
  input  wire logic [acq_pkg::PERIOD_W-1:0]     cfg_period_steps,
  input  wire logic                             cfg_route_clk_out,
  input  wire logic                             cfg_route_trig_out,
  // host commands, one-cycle pulses
  input  wire logic                             arm_cmd,
  input  wire logic                             stop_cmd,
  input  wire logic                             clear_trig_cmd,
  input  wire logic                             analog_in_host_trigger_cmd,
  input  wire logic                             global_host_trigger_cmd,
  // external pins and other functions
  input  wire logic                             ext_sample_clk_in,
  input  wire logic                             ext_trig_in,
  input  wire logic [acq_pkg::DIO_W-1:0]        digital_io_pin,
  input  wire logic [acq_pkg::DIO_W-1:0]        digital_io_is_input,
  input  wire logic                             di_trig_evt,
  input  wire logic                             do_trig_evt,
  input  wire logic [3:0]                       ao_trig_evt,
  // converter
  output logic                                  conv_start,
  input  wire logic                             adc_valid,
  input  wire logic [DATA_W-1:0]                adc_data,
  // sample stream to host
  output logic                                  up_valid,
  output logic [DATA_W-1:0]                     up_data,
  input  wire logic                             up_ready,
  // sync output pins
  output logic                                  sample_clk_out,
  output logic                                  trig_out,
  // status
  output logic                                  triggered,
  output logic                                  acq_busy,
  output logic                                  acq_done,
  output logic                                  overflow,
  output logic [acq_pkg::COUNT_W-1:0]           samples_taken
);
  localparam int CW = acq_pkg::COUNT_W;
  localparam int PW = acq_pkg::PRETRIG_W;

  // configuration registers
  acq_pkg::clk_src_e              clk_src_reg;
  acq_pkg::trig_src_e             trig_src_reg;
  logic [acq_pkg::DIO_IDX_W-1:0]  dio_sel_reg;
  logic                           finite_reg;
  logic [CW-1:0]                  total_reg;
  logic [PW-1:0]                  pretrig_reg;
  logic [acq_pkg::PERIOD_W-1:0]   period_reg;
  logic                           route_clk_reg;
  logic                           route_trig_reg;

  // state
  acq_pkg::acq_state_e            state_reg;
  acq_pkg::acq_state_e            state_next;
  logic [CW-1:0]                  count_reg;
  logic [CW-1:0]                  count_next;
  logic                           ext_clk_prev_reg;
  logic                           ext_trig_prev_reg;
  logic [acq_pkg::DIO_W-1:0]      dio_prev_reg;
  logic                           overflow_reg;

  // combinational
  logic [CW-1:0]                  total_clamped;
  logic [PW-1:0]                  pretrig_clamped;
  logic [acq_pkg::PERIOD_W-1:0]   period_clamped;
  logic                           timer_run;
  logic                           timer_tick;
  logic                           ext_clk_edge;
  logic                           sample_tick;
  logic                           dio_edge;
  logic                           trig_evt;
  logic                           pre_sampling;
  logic                           post_sampling;
  logic                           issue_conv;
  logic                           last_conv;
  logic                           evict;
  logic                           drain;
  logic                           load_out;
  logic                           in_idle;
  logic                           in_armed;
  logic                           in_run;
  logic                           pretrig_on;
  logic                           hist_full;
  logic                           ext_trig_edge;
  logic                           quiet;
  logic                           out_free;
  logic                           run_next;
  logic                           busy_next;
  logic [CW-1:0]                  count_inc;

  sample_fifo_if #(.W(DATA_W), .LVL_W(PW)) fifo_bus ();

  function automatic logic rise(input logic cur, input logic prev);
    return cur && !prev;
  endfunction

  // phase decode
  assign in_idle    = state_reg == acq_pkg::ST_IDLE;
  assign in_armed   = state_reg == acq_pkg::ST_ARMED;
  assign in_run     = state_reg == acq_pkg::ST_RUN;
  assign pretrig_on = pretrig_reg != '0;

  // shared terms of the sampling and output logic
  assign quiet      = !clear_trig_cmd && !stop_cmd;
  assign count_inc  = count_reg + CW'(1);
  assign out_free   = !up_valid || up_ready;
  assign hist_full  = fifo_bus.level >= pretrig_reg;

  // clamp host settings so a bad write cannot break the documented limits
  assign total_clamped   = (cfg_sample_total > CW'(acq_pkg::MAX_FINITE_COUNT))
                         ? CW'(acq_pkg::MAX_FINITE_COUNT)
                         : cfg_sample_total;
  assign pretrig_clamped = (cfg_pretrig_count > PW'(FIFO_DEPTH))
                         ? PW'(FIFO_DEPTH)
                         : cfg_pretrig_count;
  assign period_clamped  = (cfg_period_steps < acq_pkg::PERIOD_W'(MIN_PERIOD_STEPS))
                         ? acq_pkg::PERIOD_W'(MIN_PERIOD_STEPS)
                         : cfg_period_steps;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clk_src_reg    <= acq_pkg::CLK_SRC_INTERNAL;
      trig_src_reg   <= acq_pkg::TRIG_AI_CMD;
      dio_sel_reg    <= '0;
      finite_reg     <= 1'b0;
      total_reg      <= acq_pkg::RST_COUNT;
      pretrig_reg    <= acq_pkg::RST_PRETRIG;
      period_reg     <= acq_pkg::RST_PERIOD;
      route_clk_reg  <= 1'b0;
      route_trig_reg <= 1'b0;
    end else if (cfg_load && in_idle) begin
      clk_src_reg    <= cfg_clk_src;
      trig_src_reg   <= cfg_trig_src;
      dio_sel_reg    <= cfg_dio_sel;
      finite_reg     <= cfg_finite_count_mode;
      total_reg      <= (total_clamped == '0) ? CW'(1) : total_clamped;
      pretrig_reg    <= pretrig_clamped;
      period_reg     <= period_clamped;
      route_clk_reg  <= cfg_route_clk_out;
      route_trig_reg <= cfg_route_trig_out;
    end
  end

  // pacing: timer keeps running while routed out so other devices stay locked
  assign timer_run = !in_idle || route_clk_reg;

  pace_timer #(.PERIOD_W(acq_pkg::PERIOD_W)) u_timer (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .run          (timer_run),
    .period_steps (period_reg),
    .tick         (timer_tick)
  );

  assign ext_clk_edge = rise(ext_sample_clk_in, ext_clk_prev_reg);
  assign sample_tick  = (clk_src_reg == acq_pkg::CLK_SRC_EXTERNAL)
                      ? ext_clk_edge
                      : timer_tick;

  // trigger selection
  assign dio_edge = digital_io_is_input[dio_sel_reg]
                 && rise(digital_io_pin[dio_sel_reg], dio_prev_reg[dio_sel_reg]);
  assign ext_trig_edge = rise(ext_trig_in, ext_trig_prev_reg);

  always_comb begin
    unique case (trig_src_reg)
      acq_pkg::TRIG_AI_CMD:     trig_evt = analog_in_host_trigger_cmd;
      acq_pkg::TRIG_GLOBAL_CMD: trig_evt = global_host_trigger_cmd;
      acq_pkg::TRIG_EXT_IN:     trig_evt = ext_trig_edge;
      acq_pkg::TRIG_DIO_EDGE:   trig_evt = dio_edge;
      acq_pkg::TRIG_DI_FUNC:    trig_evt = di_trig_evt;
      acq_pkg::TRIG_DO_FUNC:    trig_evt = do_trig_evt;
      acq_pkg::TRIG_AO0_FUNC:   trig_evt = ao_trig_evt[0];
      acq_pkg::TRIG_AO1_FUNC:   trig_evt = ao_trig_evt[1];
      acq_pkg::TRIG_AO2_FUNC:   trig_evt = ao_trig_evt[2];
      acq_pkg::TRIG_AO3_FUNC:   trig_evt = ao_trig_evt[3];
      default:                  trig_evt = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ext_clk_prev_reg  <= 1'b0;
      ext_trig_prev_reg <= 1'b0;
      dio_prev_reg      <= '0;
    end else begin
      ext_clk_prev_reg  <= ext_sample_clk_in;
      ext_trig_prev_reg <= ext_trig_in;
      dio_prev_reg      <= digital_io_pin;
    end
  end

  // conversions before the trigger only feed the history; none at all with count zero
  assign pre_sampling  = in_armed && pretrig_on;
  assign post_sampling = in_run && quiet;
  assign issue_conv    = sample_tick && (pre_sampling || post_sampling);
  assign last_conv     = post_sampling && sample_tick && finite_reg
                      && (count_inc == total_reg);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      acq_pkg::ST_IDLE: begin
        if (arm_cmd) begin
          state_next = acq_pkg::ST_ARMED;
          count_next = '0;
        end
      end
      acq_pkg::ST_ARMED: begin
        if (stop_cmd) begin
          state_next = acq_pkg::ST_IDLE;
        end else if (trig_evt && !clear_trig_cmd) begin
          state_next = acq_pkg::ST_RUN;
        end
      end
      acq_pkg::ST_RUN: begin
        if (stop_cmd) begin
          state_next = acq_pkg::ST_IDLE;
        end else if (clear_trig_cmd) begin
          state_next = acq_pkg::ST_ARMED;
        end else if (last_conv) begin
          state_next = acq_pkg::ST_IDLE;
          count_next = count_inc;
        end else if (issue_conv) begin
          count_next = count_inc;
        end
      end
    endcase
  end

  // history: once the buffer holds n samples, each new one pushes out the oldest
  assign evict = in_armed && adc_valid && hist_full;
  // history stays parked until the trigger; afterwards it drains ahead of new data
  assign drain    = !in_armed;
  assign load_out = drain && !fifo_bus.empty && out_free;

  assign fifo_bus.flush = in_idle && arm_cmd;
  assign fifo_bus.push  = adc_valid && !(in_armed && !pretrig_on);
  assign fifo_bus.wdata = adc_data;
  assign fifo_bus.pop   = evict || load_out;

  sample_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH), .LVL_W(PW)) u_fifo (
    .core_clk (core_clk),
    .nrst     (nrst),
    .f        (fifo_bus.store)
  );

  // a full buffer outside the history phase loses the sample; flagged until the next arm
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      overflow_reg <= 1'b0;
    end else if (adc_valid && drain && fifo_bus.full && !load_out) begin
      overflow_reg <= 1'b1;
    end else if (fifo_bus.flush) begin
      overflow_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= acq_pkg::ST_IDLE;
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // status is taken from the next state so it moves together with the state
  assign run_next  = state_next == acq_pkg::ST_RUN;
  assign busy_next = state_next != acq_pkg::ST_IDLE;

  // registered outputs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      up_valid <= 1'b0;
      up_data  <= '0;
    end else if (load_out) begin
      up_valid <= 1'b1;
      up_data  <= fifo_bus.rdata;
    end else if (up_ready) begin
      up_valid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      conv_start     <= 1'b0;
      sample_clk_out <= 1'b0;
      trig_out       <= 1'b0;
      triggered      <= 1'b0;
      acq_busy       <= 1'b0;
      acq_done       <= 1'b0;
      overflow       <= 1'b0;
      samples_taken  <= '0;
    end else begin
      conv_start     <= issue_conv;
      sample_clk_out <= route_clk_reg && timer_tick;
      trig_out       <= route_trig_reg && run_next;
      triggered      <= run_next;
      acq_busy       <= busy_next;
      acq_done       <= last_conv && quiet;
      overflow       <= overflow_reg;
      samples_taken  <= count_next;
    end
  end

endmodule

/* File: src/pace_timer.sv */
module pace_timer #(
  parameter int PERIOD_W = acq_pkg::PERIOD_W
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                nrst,
  // control
  input  wire logic                run,
  input  wire logic [PERIOD_W-1:0] period_steps,
  // pacing output
  output logic                     tick
);
  localparam int ACC_W = PERIOD_W + 5;

  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic [ACC_W-1:0] span;
  logic [ACC_W-1:0] acc_step;
  logic             wrap;

  // accumulating nanoseconds keeps the mean period exact although 10 ns is not whole cycles
  assign span     = ACC_W'(period_steps) * ACC_W'(acq_pkg::TIMER_STEP_NS);
  assign acc_step = acc_reg + ACC_W'(acq_pkg::CLK_PERIOD_NS);
  assign wrap     = acc_step >= span;
  assign acc_next = !run ? '0 : (wrap ? acc_step - span : acc_step);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= '0;
      tick    <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      tick    <= run && wrap;
    end
  end
endmodule

/* File: src/sample_fifo.sv */
module sample_fifo #(
  parameter int W     = acq_pkg::DATA_W,
  parameter int DEPTH = acq_pkg::MAX_PRETRIG,
  parameter int LVL_W = acq_pkg::PRETRIG_W
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // store side
  sample_fifo_if.store f
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [W-1:0]     mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [LVL_W-1:0] level_reg;
  logic             do_pop;
  logic             do_push;

  assign do_pop   = f.pop && !f.empty;
  // a push into a full buffer only lands when a pop frees a slot in the same cycle
  assign do_push  = f.push && (!f.full || do_pop);
  assign f.rdata  = mem[rd_ptr_reg];
  assign f.level  = level_reg;
  assign f.full   = level_reg == LVL_W'(DEPTH);
  assign f.empty  = level_reg == '0;

  function automatic logic [PTR_W-1:0] inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= f.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg  <= '0;
    end else if (f.flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg  <= '0;
    end else begin
      if (do_push) wr_ptr_reg <= inc(wr_ptr_reg);
      if (do_pop) rd_ptr_reg <= inc(rd_ptr_reg);
      level_reg <= level_reg + LVL_W'(do_push) - LVL_W'(do_pop);
    end
  end
endmodule
